// ### logic/irq_prio_consts.svh
// offsets, field positions and reset values of the interrupt priority block
// Behaviour
// - 3-bit priority field, 111 means level 7
// - priority 000 never requests the CPU
// - codes 001..111 map to levels 1..7
// - reset sets every priority field to 4
// - bits 15, 11, 7, 3 ignore writes, read 0
// - CAN event 14:12, CAN receive 10:8
// - serial2 event 6:4, serial2 error 2:0
// - control bit 15 stops user interrupt nesting
// - per-source pending flag and enable bit
// - cleared enable blocks request despite pending flag
// - flag stays set until software clears it
// - trap request persists while trap flag set
// - return restores saved PC, status byte, level
// - OR 0eh into status byte masks all users
// - traps at levels 8..15 masked only by an equal or higher CPU level
// - timed disable masks levels 1..6 only
`ifndef IRQ_PRIO_CONSTS_SVH
`define IRQ_PRIO_CONSTS_SVH

// ****************************************************************
// register byte offsets on the bus
// ****************************************************************
`define OFS_PRIO 12'h000
`define OFS_FLAG 12'h004
`define OFS_ENAB 12'h008
`define OFS_CTL1 12'h00c
`define OFS_SRL 12'h010
`define OFS_TIMED_IRQ_DISABLE 12'h014
`define OFS_STAT 12'h018

// ****************************************************************
// field positions
// ****************************************************************
`define POS_CAN_EVENT 12
`define POS_CAN_RX 8
`define POS_SER2_EVENT 4
`define POS_SER2_ERROR 0
`define POS_NESTING_OFF 15
`define POS_SRL_LEVEL 1
`define POS_STAT_REQ_LVL 4
`define POS_STAT_REQ_ID 8
`define POS_STAT_REQ 13
`define POS_STAT_OVF 14

// ****************************************************************
// reset values, masks and level limits
// ****************************************************************
`define PRIO_RST 16'h4444
`define PRIO_MASK 16'h7777
`define SRL_RST 8'h00
`define IRQ_OFF_OR 8'h0e
`define LVL_TIMED_IRQ_DISABLE_TOP 4'h6
`define LVL_USER_TOP 4'h7

`endif

// ### logic/irq_prio_pkg.sv
// types shared by the interrupt priority block
package irq_prio_pkg;
	// 4-bit priority level, 8..15 are trap levels
	typedef logic [3:0] level_t;
	// 3-bit user priority code
	typedef logic [2:0] prio_t;
	// bus slave phase
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DONE = 2'b10
	} bus_state_t;
endpackage

// ### logic/irq_pick_if.sv
// carrier between the controller and its priority arbiter
`timescale 1ns/1ps
interface irq_pick_if #(
	parameter int NSRC = 4,
	parameter int NTRAP = 8
);
	import irq_prio_pkg::*;
	logic [NSRC*3-1:0] prio; // packed priority codes
	logic [NSRC-1:0] pend; // pending and enabled sources
	logic [NTRAP-1:0] trap; // trap flags
	level_t win_lvl; // winning level
	logic [4:0] win_id; // winning source or trap index
	logic win_valid; // any candidate at all
	modport arb(input prio, input pend, input trap,
		output win_lvl, output win_id, output win_valid);
	modport ctl(output prio, output pend, output trap,
		input win_lvl, input win_id, input win_valid);
endinterface

// ### logic/irq_prio_arbiter.sv
// combinational pick of the highest pending request
`timescale 1ns/1ps
module irq_prio_arbiter
	import irq_prio_pkg::*;
#(
	parameter int NSRC = 4,
	parameter int NTRAP = 8
) (
	// candidates in, winner out
	irq_pick_if.arb pick
);
	level_t best_lvl; // level found so far
	logic [4:0] best_id; // index found so far
	logic best_v; // something found

	// field of one source, used for both test and level
	function automatic prio_t code_of(input logic [NSRC*3-1:0] v,
		input int i);
		code_of = v[i*3 +: 3];
	endfunction

	// ascending scan with strict compare: lower index wins a tie
	always_comb begin
		best_lvl = 4'h0;
		best_id = 5'h00;
		best_v = 1'b0;
		for (int i = 0; i < NSRC; i++) begin
			// code 000 is no candidate at all
			if (pick.pend[i] && code_of(pick.prio, i) != 3'b000 &&
				{1'b0, code_of(pick.prio, i)} > best_lvl) begin
				best_lvl = {1'b0, code_of(pick.prio, i)};
				best_id = 5'(i);
				best_v = 1'b1;
			end
		end
		// traps sit above every user level, highest index first
		for (int t = 0; t < NTRAP; t++) begin
			if (pick.trap[t]) begin
				best_lvl = 4'(8 + t);
				best_id = 5'(t);
				best_v = 1'b1;
			end
		end
	end

	assign pick.win_lvl = best_lvl;
	assign pick.win_id = best_id;
	assign pick.win_valid = best_v;
endmodule

// ### logic/irq_timed_irq_disable_timer.sv
// timed disable counter for the lower user levels
`timescale 1ns/1ps
module irq_timed_irq_disable_timer
	import irq_prio_pkg::*;
#(
	parameter int DISW = 14
) (
	// clock, reset and freeze
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// software load
	input wire logic load,
	input wire logic [DISW-1:0] load_val,
	// state
	output logic [DISW-1:0] count_q,
	output logic busy
);
	// remaining cycles; a reload simply restarts the window
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_q <= '0;
		end else if (ce) begin
			if (load) begin
				count_q <= load_val;
			end else if (count_q != '0) begin
				count_q <= count_q - DISW'(1);
			end
		end
	end

	assign busy = (count_q != '0);

	// ****************************************************************
	// checks
	// ****************************************************************
	AST_TIMED_IRQ_DISABLE_DOWN: assert property (@(posedge clk_sys) disable iff (rst)
		busy && ce && !load |=> count_q == $past(count_q) - DISW'(1))
		else $error("timed disable count did not step down");
endmodule

// ### logic/interrupt_priority_control.sv
// interrupt priority, masking, nesting and return control with APB access
`timescale 1ns/1ps
`include "irq_prio_consts.svh"
module interrupt_priority_control
	import irq_prio_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int PCW = 24,
	parameter int DISW = 14
) (
	// clock, reset and freeze
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// peripheral and trap events, one-cycle pulses
	input wire logic [3:0] src_event,
	input wire logic [7:0] trap_event,
	// CPU core
	input wire logic core_ack,
	input wire logic [PCW-1:0] core_pc,
	input wire logic core_return,
	output logic irq_req,
	output logic [4:0] irq_id,
	output logic [3:0] irq_level,
	output logic [PCW-1:0] ret_pc,
	output logic ret_valid,
	output logic [3:0] cpu_level
);
	localparam int NSRC = 4; // sources of the priority register
	localparam int NTRAP = 8; // levels 8..15
	localparam int SW = $clog2(DEPTH); // stack index width
	localparam int DW = $clog2(DEPTH + 1); // depth counter width

	// ****************************************************************
	// state
	// ****************************************************************
	bus_state_t bus_q; // APB phase
	logic [31:0] prdata_q; // read data
	logic pready_q; // access answer
	logic pslverr_q; // unmapped access
	logic [15:0] prio_q; // irq_priority_ctrl_8
	logic [NSRC-1:0] flag_q; // irq_flag_regs
	logic [NSRC-1:0] enab_q; // irq_enable_regs
	logic nesting_off_q; // irq_control_one bit 15
	logic [NTRAP-1:0] trap_q; // trap status flags
	logic [7:0] srl_q; // status_low_byte
	logic ipl3_q; // trap-level bit of the CPU level
	logic [DW-1:0] depth_q; // nested services on the stack
	logic ovf_q; // push attempted while stack full
	logic irq_req_q; // request to the core
	logic [4:0] irq_id_q; // index of the request
	level_t irq_level_q; // level of the request
	logic [PCW-1:0] ret_pc_q; // restored program counter
	logic ret_valid_q; // restore pulse
	// return stack, no reset needed: read only below depth
	logic [PCW-1:0] stk_pc_q [DEPTH];
	logic [7:0] stk_srl_q [DEPTH];
	logic stk_ipl3_q [DEPTH];

	// ****************************************************************
	// combinational helpers
	// ****************************************************************
	logic bus_take; // access edge of a transfer
	logic wr_take; // write takes effect here
	logic [31:0] rd_mux; // read data of the addressed register
	logic rd_err; // address maps to nothing
	level_t cpu_lvl; // current CPU priority level
	logic in_svc; // a service routine is running
	logic [SW-1:0] top_idx; // top of the stack
	logic allow; // winner may be presented
	logic [NSRC-1:0] flag_clr; // software clears
	logic [NTRAP-1:0] trap_clr; // software clears
	logic [DISW-1:0] timed_irq_disable_count; // timed disable remaining
	logic timed_irq_disable_busy; // timed disable running

	// address decode shared by reads and writes
	function automatic logic is_reg(input logic [11:0] a,
		input logic [11:0] ofs);
		is_reg = (a == ofs);
	endfunction

	assign bus_take = (bus_q == BUS_DONE) && psel && penable;
	assign wr_take = bus_take && pwrite;
	assign cpu_lvl = {ipl3_q, srl_q[`POS_SRL_LEVEL +: 3]};
	assign in_svc = (depth_q != '0);
	assign top_idx = SW'(depth_q - DW'(1));

	// ****************************************************************
	// priority arbiter and timed disable
	// ****************************************************************
	irq_pick_if #(.NSRC(NSRC), .NTRAP(NTRAP)) pick ();
	// packed codes, reserved bits squeezed out
	assign pick.prio = {prio_q[14:12], prio_q[10:8], prio_q[6:4],
		prio_q[2:0]};
	assign pick.pend = flag_q & enab_q;
	assign pick.trap = trap_q;

	irq_prio_arbiter #(.NSRC(NSRC), .NTRAP(NTRAP)) u_arb (
		.pick(pick.arb)
	);

	irq_timed_irq_disable_timer #(.DISW(DISW)) u_timed_irq_disable (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.load(wr_take && is_reg(paddr, `OFS_TIMED_IRQ_DISABLE)),
		.load_val(pwdata[DISW-1:0]),
		.count_q(timed_irq_disable_count),
		.busy(timed_irq_disable_busy)
	);

	// masking: user levels by CPU level, nesting and timed disable
	always_comb begin
		allow = 1'b0;
		if (pick.win_valid && pick.win_lvl > cpu_lvl) begin
			if (pick.win_lvl[3]) begin
				allow = 1'b1;
			end else if (nesting_off_q && in_svc) begin
				allow = 1'b0;
			end else if (timed_irq_disable_busy && pick.win_lvl <= `LVL_TIMED_IRQ_DISABLE_TOP) begin
				allow = 1'b0;
			end else begin
				allow = 1'b1;
			end
		end
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// read mux; reserved bits come back as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		if (is_reg(paddr, `OFS_PRIO)) begin
			rd_mux[15:0] = prio_q & `PRIO_MASK;
		end else if (is_reg(paddr, `OFS_FLAG)) begin
			rd_mux[NSRC-1:0] = flag_q;
		end else if (is_reg(paddr, `OFS_ENAB)) begin
			rd_mux[NSRC-1:0] = enab_q;
		end else if (is_reg(paddr, `OFS_CTL1)) begin
			rd_mux[`POS_NESTING_OFF] = nesting_off_q;
			rd_mux[NTRAP-1:0] = trap_q;
		end else if (is_reg(paddr, `OFS_SRL)) begin
			rd_mux[7:0] = srl_q;
		end else if (is_reg(paddr, `OFS_TIMED_IRQ_DISABLE)) begin
			rd_mux[DISW-1:0] = timed_irq_disable_count;
		end else if (is_reg(paddr, `OFS_STAT)) begin
			rd_mux[3:0] = cpu_lvl;
			rd_mux[`POS_STAT_REQ_LVL +: 4] = irq_level_q;
			rd_mux[`POS_STAT_REQ_ID +: 5] = irq_id_q;
			rd_mux[`POS_STAT_REQ] = irq_req_q;
			rd_mux[`POS_STAT_OVF] = ovf_q;
		end else begin
			rd_err = 1'b1; // unmapped answers with an error
		end
	end

	// one wait state: answer on the second access cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_q <= BUS_IDLE;
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			case (bus_q)
				BUS_IDLE: begin
					if (psel && penable) begin
						bus_q <= BUS_DONE;
						pready_q <= 1'b1;
						prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
						pslverr_q <= rd_err;
					end
				end
				BUS_DONE: begin
					bus_q <= BUS_IDLE;
					pready_q <= 1'b0;
					pslverr_q <= 1'b0;
				end
				default: begin
					bus_q <= BUS_IDLE;
					pready_q <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// software registers
	// ****************************************************************
	// priority fields; reserved bits never store
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prio_q <= `PRIO_RST;
		end else if (ce && wr_take && is_reg(paddr, `OFS_PRIO)) begin
			prio_q <= pwdata[15:0] & `PRIO_MASK;
		end
	end

	// write-one-to-clear masks; an event in the same cycle wins
	assign flag_clr = (wr_take && is_reg(paddr, `OFS_FLAG)) ?
		pwdata[NSRC-1:0] : '0;
	assign trap_clr = (wr_take && is_reg(paddr, `OFS_CTL1)) ?
		pwdata[NTRAP-1:0] : '0;

	// pending flags stay until cleared by software
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_q <= '0;
		end else if (ce) begin
			flag_q <= (flag_q & ~flag_clr) | src_event;
		end
	end

	// trap flags: the request persists until the handler clears it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			trap_q <= '0;
		end else if (ce) begin
			trap_q <= (trap_q & ~trap_clr) | trap_event;
		end
	end

	// enables and nesting control
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			enab_q <= '0;
			nesting_off_q <= 1'b0;
		end else if (ce && wr_take) begin
			if (is_reg(paddr, `OFS_ENAB)) begin
				enab_q <= pwdata[NSRC-1:0];
			end else if (is_reg(paddr, `OFS_CTL1)) begin
				nesting_off_q <= pwdata[`POS_NESTING_OFF];
			end
		end
	end

	// ****************************************************************
	// service entry and return
	// ****************************************************************
	// core actions win over a bus write in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			srl_q <= `SRL_RST;
			ipl3_q <= 1'b0;
			depth_q <= '0;
			ovf_q <= 1'b0;
			ret_pc_q <= '0;
			ret_valid_q <= 1'b0;
		end else if (ce) begin
			ret_valid_q <= 1'b0;
			if (core_ack && irq_req_q) begin
				// the CPU level rises to that of the taken request
				srl_q[`POS_SRL_LEVEL +: 3] <= irq_level_q[2:0];
				ipl3_q <= irq_level_q[3];
				if (depth_q != DW'(DEPTH)) begin
					depth_q <= depth_q + DW'(1);
				end else begin
					ovf_q <= 1'b1; // too deep: the old context is lost
				end
			end else if (core_return && in_svc) begin
				srl_q <= stk_srl_q[top_idx];
				ipl3_q <= stk_ipl3_q[top_idx];
				ret_pc_q <= stk_pc_q[top_idx];
				ret_valid_q <= 1'b1;
				depth_q <= depth_q - DW'(1);
			end else if (wr_take && is_reg(paddr, `OFS_SRL)) begin
				srl_q <= pwdata[7:0];
			end
		end
	end

	// stack push of the interrupted context
	always_ff @(posedge clk_sys) begin
		if (ce && core_ack && irq_req_q && depth_q != DW'(DEPTH)) begin
			stk_pc_q[depth_q[SW-1:0]] <= core_pc;
			stk_srl_q[depth_q[SW-1:0]] <= srl_q;
			stk_ipl3_q[depth_q[SW-1:0]] <= ipl3_q;
		end
	end

	// request to the core; dropped at the taking edge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_req_q <= 1'b0;
			irq_id_q <= 5'h00;
			irq_level_q <= 4'h0;
		end else if (ce) begin
			irq_req_q <= allow && !(core_ack && irq_req_q);
			irq_id_q <= pick.win_id;
			irq_level_q <= pick.win_lvl;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq_req = irq_req_q;
	assign irq_id = irq_id_q;
	assign irq_level = irq_level_q;
	assign ret_pc = ret_pc_q;
	assign ret_valid = ret_valid_q;
	assign cpu_level = {ipl3_q, srl_q[`POS_SRL_LEVEL +: 3]};

	// ****************************************************************
	// checks
	// ****************************************************************
	prio_t req_code; // code of the requesting user source
	level_t top_srl_lvl; // level that a return would restore
	assign req_code = prio_q[{irq_id_q[1:0], 2'b00} +: 3];
	assign top_srl_lvl = {stk_ipl3_q[top_idx],
		stk_srl_q[top_idx][`POS_SRL_LEVEL +: 3]};

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_RESERVED_ZERO: assert property (
		(prio_q & ~`PRIO_MASK) == 16'h0000)
		else $error("reserved priority bits hold a one");
	AST_RESET_LEVEL4: assert property (
		$past(rst) |-> prio_q == `PRIO_RST)
		else $error("priority fields not level 4 after reset");
	AST_LEVEL_IS_CODE: assert property (
		irq_req_q && !irq_level_q[3] && $stable(prio_q) |->
		req_code != 3'b000 && {1'b0, req_code} == irq_level_q)
		else $error("user request level differs from its code");
	AST_ENABLE_GATES: assert property (
		irq_req_q && !irq_level_q[3] && $stable(enab_q) && $stable(flag_q) |->
		enab_q[irq_id_q[1:0]] && flag_q[irq_id_q[1:0]])
		else $error("request from a disabled or idle source");
	AST_FLAG_STICKY: assert property (
		!$past(wr_take) |-> (flag_q & $past(flag_q)) == $past(flag_q))
		else $error("pending flag fell without a software clear");
	AST_TRAP_STICKY: assert property (
		!$past(wr_take) |-> (trap_q & $past(trap_q)) == $past(trap_q))
		else $error("trap flag fell without a software clear");
	AST_NEST_BLOCK: assert property (
		irq_req_q && $past(nesting_off_q) && $past(in_svc) |->
		irq_level_q[3])
		else $error("user source nested while nesting is off");
	AST_ABOVE_CPU: assert property (
		irq_req_q |-> irq_level_q > $past(cpu_lvl))
		else $error("request not above the CPU level");
	AST_USER_MASKED: assert property (
		$past(cpu_lvl) == `LVL_USER_TOP |-> !irq_req_q || irq_level_q[3])
		else $error("user request passed at CPU level 7");
	AST_TIMED_IRQ_DISABLE_LOW: assert property (
		irq_req_q && $past(timed_irq_disable_busy) |-> irq_level_q > `LVL_TIMED_IRQ_DISABLE_TOP)
		else $error("level 1..6 request during timed disable");
	AST_TRAP_PASSES: assert property (
		ce && (|trap_q) && !cpu_lvl[3] && !(core_ack && irq_req_q) |=>
		irq_req_q && irq_level_q[3])
		else $error("trap request was masked");
	AST_RETURN_LEVEL: assert property (
		ce && core_return && in_svc && !(core_ack && irq_req_q) |=>
		ret_valid_q && cpu_lvl == $past(top_srl_lvl))
		else $error("return did not restore the saved level");
endmodule

// ### testbench/core_model.sv
// behavioural processor core that takes and returns from interrupts
`timescale 1ns/1ps
module core_model #(
	parameter int PCW = 24
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bench control
	input wire logic ack_en,
	input wire logic [1:0] ack_wait,
	input wire logic ret_cmd,
	// controller side
	input wire logic irq_req,
	output logic core_ack,
	output logic [PCW-1:0] core_pc,
	output logic core_return
);
	logic [1:0] wait_q; // cycles spent before taking
	logic [PCW-1:0] next_q; // pc of the next saved context
	logic want; // a request we may take
	assign want = ack_en && irq_req && !core_ack;
	// take after a chosen delay, so slow cores are covered too
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_ack <= 1'b0;
			core_pc <= '0;
			core_return <= 1'b0;
			wait_q <= 2'h0;
			next_q <= PCW'(32'h100);
		end else begin
			core_return <= ret_cmd;
			if (want && wait_q == ack_wait) begin
				core_ack <= 1'b1;
				core_pc <= next_q;
				next_q <= next_q + PCW'(32'h10);
				wait_q <= 2'h0;
			end else begin
				// pc means nothing without ack, so keep it moving
				core_ack <= 1'b0;
				core_pc <= ~core_pc;
				wait_q <= want ? wait_q + 2'h1 : 2'h0;
			end
		end
	end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the interrupt priority block
`timescale 1ns/1ps
`include "irq_prio_consts.svh"
module testbench;
	import irq_prio_pkg::*;
	// ****************************************************************
	// pins, bench controls and model state
	// ****************************************************************
	logic clk_sys = 0, rst = 1, ce = 1;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, v;
	logic pready, pslverr, er;
	logic [3:0] src_event = 0;
	logic [7:0] trap_event = 0;
	logic core_ack, core_return, irq_req, ret_valid;
	logic [23:0] core_pc, ret_pc;
	logic [4:0] irq_id;
	logic [3:0] irq_level, cpu_level;
	logic ack_en = 0, ret_cmd = 0;
	logic [1:0] ack_wait = 0;
	int num_errors = 0, total_checks = 0, seed = 48, i;
	int m_prio = 'h4444, m_flag, m_en, m_trap, m_cpu, m_nest, m_timed_irq_disable, e_lvl;
	int m_cpuq[$]; // saved levels, newest last
	logic [23:0] m_pcq[$]; // saved pcs, newest last
	always #20 clk_sys = ~clk_sys;
	interrupt_priority_control #(.PCW(24)) uut (.clk_sys(clk_sys),
		.rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_event(src_event),
		.trap_event(trap_event), .core_ack(core_ack), .core_pc(core_pc),
		.core_return(core_return), .irq_req(irq_req), .irq_id(irq_id),
		.irq_level(irq_level), .ret_pc(ret_pc), .ret_valid(ret_valid),
		.cpu_level(cpu_level));
	core_model #(.PCW(24)) core (.clk_sys(clk_sys), .rst(rst),
		.ack_en(ack_en), .ack_wait(ack_wait), .ret_cmd(ret_cmd),
		.irq_req(irq_req), .core_ack(core_ack), .core_pc(core_pc),
		.core_return(core_return));
	// ****************************************************************
	// compare, verdict and bus tasks
	// ****************************************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// one apb transfer, held until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
		@(posedge clk_sys);
		penable <= 1;
		k = 0;
		do begin @(posedge clk_sys); k++; end while (pready !== 1 && k < 50);
		if (k >= 50) num_errors++;
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// model pick: highest enabled level, lowest index wins a tie
	task look;
		int lvl, id, l, j;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		lvl = 0;
		id = 0;
		for (j = 0; j < 4; j++) begin
			l = (m_prio >> (4 * j)) & 7;
			if (m_flag[j] && m_en[j] && l != 0 && !(m_timed_irq_disable && l <= 6) &&
				!(m_nest && m_cpuq.size() > 0) && l > lvl) begin
				lvl = l;
				id = j;
			end
		end
		for (j = 0; j < 8; j++) if (m_trap[j]) begin lvl = 8 + j; id = j; end
		e_lvl = lvl;
		chk(irq_req, lvl > m_cpu);
		if (lvl > m_cpu) begin
			chk(irq_id, id);
			chk(irq_level, lvl);
		end
		chk(cpu_level, m_cpu);
	endtask
	task setp(input logic [31:0] d);
		apb(1, `OFS_PRIO, d);
		m_prio = d & 'h7777;
		look;
	endtask
	task en(input logic [31:0] d);
		apb(1, `OFS_ENAB, d);
		m_en = d;
		look;
	endtask
	task clrf(input logic [31:0] d);
		apb(1, `OFS_FLAG, d);
		m_flag &= ~d;
	endtask
	task ctl(input logic [31:0] d);
		apb(1, `OFS_CTL1, d);
		m_nest = d[15];
		m_trap &= ~(d & 'hff);
	endtask
	task pulse(input logic [3:0] s, input logic [7:0] t);
		@(posedge clk_sys);
		src_event <= s;
		trap_event <= t;
		@(posedge clk_sys);
		src_event <= 0;
		trap_event <= 0;
		m_flag |= s;
		m_trap |= t;
		look;
	endtask
	// core takes the request after a random delay
	task serve;
		int k;
		@(posedge clk_sys);
		ack_en <= 1;
		ack_wait <= 2'($random(seed));
		k = 0;
		while (core_ack !== 1 && k < 20) begin @(negedge clk_sys); k++; end
		if (k >= 20) num_errors++;
		@(posedge clk_sys);
		ack_en <= 0;
		m_pcq.push_back(core_pc);
		m_cpuq.push_back(m_cpu);
		m_cpu = e_lvl;
		look;
	endtask
	task ret;
		int k;
		@(posedge clk_sys);
		ret_cmd <= 1;
		@(posedge clk_sys);
		ret_cmd <= 0;
		k = 0;
		while (ret_valid !== 1 && k < 20) begin @(negedge clk_sys); k++; end
		chk(ret_valid, 1'b1);
		chk(ret_pc, m_pcq.pop_back());
		m_cpu = m_cpuq.pop_back();
		look;
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		apb(0, `OFS_PRIO, 0);
		chk(rd, 32'h4444);
		apb(0, 12'h020, 0);
		chk({rd[30:0], er}, 32'h1);
		// random layouts, unused bits stay zero
		repeat (6) begin
			v = $random(seed);
			setp(v);
			apb(0, `OFS_PRIO, 0);
			chk(rd, v & 32'h7777);
		end
		en(4'hf);
		for (i = 0; i < 4; i++) begin
			setp((i + 2) << (4 * i));
			pulse(4'(1 << i), 0);
			serve;
			clrf(1 << i);
			ret;
		end
		setp(0);
		pulse(1, 0);
		setp(3);
		en(0);
		en(4'hf);
		serve;
		ret;
		clrf(1);
		look;
		setp('h5755);
		pulse(4'hf, 0);
		setp('h5555);
		clrf(4'hf);
		// nesting off holds back a higher source
		setp('h0062);
		ctl(32'h8000);
		pulse(1, 0);
		serve;
		pulse(2, 0);
		ctl(0);
		look;
		clrf(3);
		ret;
		// status byte raise and traps above it
		setp('h0007);
		apb(0, `OFS_SRL, 0);
		apb(1, `OFS_SRL, rd | 32'h0e);
		m_cpu = 7;
		pulse(1, 0);
		pulse(0, 8'h24);
		serve;
		ctl(32'h20);
		ret;
		serve;
		ctl(32'h04);
		ret;
		apb(1, `OFS_SRL, 0);
		m_cpu = 0;
		look;
		clrf(1);
		// timed disable spares level 7
		setp('h0076);
		apb(1, `OFS_TIMED_IRQ_DISABLE, 200);
		m_timed_irq_disable = 1;
		pulse(1, 0);
		pulse(2, 0);
		serve;
		clrf(2);
		ret;
		repeat (220) @(posedge clk_sys);
		m_timed_irq_disable = 0;
		apb(0, `OFS_TIMED_IRQ_DISABLE, 0);
		chk(rd, 32'h0);
		look;
		clrf(1);
		look;
		// frozen clock enable: an event must not set its flag
		@(posedge clk_sys);
		ce <= 0;
		src_event <= 4'h1;
		@(posedge clk_sys);
		src_event <= 0;
		repeat (3) @(posedge clk_sys);
		ce <= 1;
		look;
		conclude;
	end
	// hang guard well past the expected run
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		conclude;
	end
endmodule
